// File: power_down_mode_control.sv
// Power-down mode controller: sleep, software standby, deep software standby
// and per-module standby. Assumes the CPU pulses sleepExec on the clock when its
// sleep instruction completes, and that rst_b is the power-on reset pin.
`timescale 1ns/100ps
`default_nettype none

module power_down_mode_control
	import power_down_pkg::*;
#(
	parameter int RegCount = power_down_pkg::STOP_REG_COUNT,
	parameter int RegWidth = power_down_pkg::STOP_REG_WIDTH,
	parameter logic [RegCount*RegWidth-1:0] StopReset =
		power_down_pkg::MODULE_STOP_RESET[RegCount*RegWidth-1:0]
) (
	// Clock and power-on reset pin
	input wire logic clk,
	input wire logic rst_b,
	// CPU side, same clock
	input wire logic sleepExec,
	input wire logic busIdle,
	input wire logic standbySelect,
	input wire logic standbyDepthSelect,
	// Module stop bits, one write strobe per stop register
	input wire logic [RegCount-1:0] moduleStopWe,
	input wire logic [RegWidth-1:0] moduleStopData,
	// Wake-up pins, asynchronous
	input wire logic nmiPin,
	input wire logic irqPin,
	// Power controls
	output logic clockGenHalt,
	output logic cpuHalt,
	output logic cpuRegsHeld,
	output logic memHalt,
	output logic periphHalt,
	output logic contentsUndefined,
	output logic [RegCount*RegWidth-1:0] moduleHalt,
	output logic [2:0] powerState
);
	import power_down_pkg::*;

	localparam int ModCount = RegCount * RegWidth;

	// ==========================================================
	// Reset release and pin synchronisers
	logic [SYNC_STAGES-1:0] rstPipe_reg;
	logic rstSync;
	logic [SYNC_STAGES-1:0] nmiPipe_reg;
	logic [SYNC_STAGES-1:0] irqPipe_reg;
	logic nmiSync;
	logic irqSync;

	// Release is delayed two edges so every flop leaves reset together
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstPipe_reg <= '0;
		end else begin
			rstPipe_reg <= {rstPipe_reg[SYNC_STAGES-2:0], 1'b1};
		end
	end
	assign rstSync = rstPipe_reg[SYNC_STAGES-1];

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			nmiPipe_reg <= '0;
			irqPipe_reg <= '0;
		end else begin
			nmiPipe_reg <= {nmiPipe_reg[SYNC_STAGES-2:0], nmiPin};
			irqPipe_reg <= {irqPipe_reg[SYNC_STAGES-2:0], irqPin};
		end
	end
	assign nmiSync = nmiPipe_reg[SYNC_STAGES-1];
	assign irqSync = irqPipe_reg[SYNC_STAGES-1];

	// ==========================================================
	// Mode decode
	function automatic power_state_e decodeMode(input logic sel, input logic depth);
		if (sel == STANDBY_SELECT_SLEEP) begin
			return ST_SLEEP;
		end else if (depth == STANDBY_DEPTH_SOFT) begin
			return ST_SOFT_STANDBY;
		end else begin
			return ST_DEEP_STANDBY;
		end
	endfunction

	// ==========================================================
	// Mode state machine
	power_state_e state_reg;
	power_state_e state_next;
	power_state_e pending_reg;
	power_state_e pending_next;
	logic wake;

	assign wake = nmiSync | irqSync;

	always_comb begin
		state_next = state_reg;
		pending_next = pending_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (sleepExec) begin
					pending_next = decodeMode(standbySelect, standbyDepthSelect);
					state_next = ST_WAIT_BUS;
				end
			end
			ST_WAIT_BUS: begin
				if (busIdle) begin
					state_next = pending_reg;
				end
			end
			ST_SLEEP: begin
				state_next = ST_SLEEP;
			end
			ST_SOFT_STANDBY: begin
				if (wake) begin
					state_next = ST_RUN;
				end
			end
			ST_DEEP_STANDBY: begin
				state_next = ST_DEEP_STANDBY;
			end
		endcase
	end

	// ==========================================================
	// Output decode
	logic clockGenHalt_next;
	logic cpuHalt_next;
	logic cpuRegsHeld_next;
	logic memHalt_next;
	logic periphHalt_next;
	logic contentsUndefined_next;

	always_comb begin
		clockGenHalt_next = 1'b0;
		cpuHalt_next = 1'b0;
		cpuRegsHeld_next = 1'b0;
		memHalt_next = 1'b0;
		periphHalt_next = 1'b0;
		contentsUndefined_next = 1'b0;
		unique case (state_next)
			ST_RUN: begin
				cpuHalt_next = 1'b0;
			end
			ST_WAIT_BUS: begin
				// CPU has stopped issuing; clocks stay up until the bus is quiet
				cpuHalt_next = 1'b1;
				cpuRegsHeld_next = 1'b1;
			end
			ST_SLEEP: begin
				cpuHalt_next = 1'b1;
				cpuRegsHeld_next = 1'b1;
			end
			ST_SOFT_STANDBY: begin
				clockGenHalt_next = 1'b1;
				cpuHalt_next = 1'b1;
				periphHalt_next = 1'b1;
				cpuRegsHeld_next = 1'b1;
				memHalt_next = 1'b1;
			end
			ST_DEEP_STANDBY: begin
				clockGenHalt_next = 1'b1;
				cpuHalt_next = 1'b1;
				periphHalt_next = 1'b1;
				memHalt_next = 1'b1;
				contentsUndefined_next = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// Module stop bits
	logic [ModCount-1:0] moduleStop_reg;
	logic [ModCount-1:0] moduleStop_next;

	always_comb begin
		moduleStop_next = moduleStop_reg;
		for (int i = 0; i < RegCount; i++) begin
			if (moduleStopWe[i]) begin
				moduleStop_next[i*RegWidth +: RegWidth] = moduleStopData;
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			state_reg <= ST_RUN;
			pending_reg <= ST_SLEEP;
			moduleStop_reg <= StopReset;
			moduleHalt <= StopReset;
			clockGenHalt <= 1'b0;
			cpuHalt <= 1'b0;
			cpuRegsHeld <= 1'b0;
			memHalt <= 1'b0;
			periphHalt <= 1'b0;
			contentsUndefined <= 1'b0;
			powerState <= 3'h0;
		end else begin
			state_reg <= state_next;
			pending_reg <= pending_next;
			moduleStop_reg <= moduleStop_next;
			moduleHalt <= moduleStop_next;
			clockGenHalt <= clockGenHalt_next;
			cpuHalt <= cpuHalt_next;
			cpuRegsHeld <= cpuRegsHeld_next;
			memHalt <= memHalt_next;
			periphHalt <= periphHalt_next;
			contentsUndefined <= contentsUndefined_next;
			powerState <= 3'(state_next);
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstSync);

	sequence sleepIssued;
		state_reg == ST_RUN && sleepExec;
	endsequence

	sequence drainDone(power_state_e target);
		state_reg == ST_WAIT_BUS && busIdle && pending_reg == target;
	endsequence

	AST_SLEEP_ENTRY: assert property (drainDone(ST_SLEEP) |=>
		state_reg == ST_SLEEP && cpuHalt && !clockGenHalt && !periphHalt && !memHalt)
		else $error("sleep entry did not halt only the CPU");

	AST_SOFT_ENTRY: assert property (drainDone(ST_SOFT_STANDBY) |=>
		clockGenHalt && cpuHalt && periphHalt)
		else $error("software standby entry did not stop all clocks");

	AST_SOFT_RETAIN: assert property (state_reg == ST_SOFT_STANDBY |->
		cpuRegsHeld && memHalt && !contentsUndefined)
		else $error("software standby lost retention");

	AST_SOFT_WAKE: assert property (state_reg == ST_SOFT_STANDBY && (nmiSync || irqSync) |=>
		state_reg == ST_RUN && !cpuHalt && !clockGenHalt)
		else $error("interrupt did not wake software standby");

	AST_DEEP_ENTRY: assert property (drainDone(ST_DEEP_STANDBY) |=>
		clockGenHalt && cpuHalt && periphHalt)
		else $error("deep standby entry did not stop all clocks");

	AST_DEEP_UNDEF: assert property (state_reg == ST_DEEP_STANDBY |->
		contentsUndefined && !cpuRegsHeld)
		else $error("deep standby did not flag contents undefined");

	AST_DEEP_NO_WAKE: assert property (state_reg == ST_DEEP_STANDBY && (nmiSync || irqSync) |=>
		state_reg == ST_DEEP_STANDBY && cpuHalt)
		else $error("interrupt left deep standby");

	for (genvar g = 0; g < RegCount; g++) begin : gStopChk
		AST_STOP_WRITE: assert property (moduleStopWe[g] |=>
			moduleHalt[g*RegWidth +: RegWidth] == $past(moduleStopData))
			else $error("module stop write not reflected");
		AST_STOP_CLEAR: assert property (moduleStopWe[g] && moduleStopData == '0 |=>
			moduleHalt[g*RegWidth +: RegWidth] == '0)
			else $error("cleared stop bits did not release modules");
	end

	AST_MODULE_CPU_RUNS: assert property (state_reg == ST_RUN && moduleHalt != '0 |->
		!cpuHalt && !clockGenHalt)
		else $error("module standby halted the CPU");

	AST_RESET_STOP: assert property ($rose(rstSync) |->
		moduleHalt == StopReset)
		else $error("reset did not restore stop bits");

	AST_SAMPLE_WAIT: assert property (sleepIssued |=>
		state_reg == ST_WAIT_BUS && cpuHalt && !clockGenHalt)
		else $error("sleep request did not wait for bus drain");

	// Clocks and memory must stay up for as long as the bus is still busy
	AST_DRAIN_HOLD: assert property (state_reg == ST_WAIT_BUS && !busIdle |=>
		state_reg == ST_WAIT_BUS && !clockGenHalt && !memHalt)
		else $error("mode entered before the bus drained");

	AST_SAMPLE_MODE: assert property (sleepIssued |=>
		pending_reg == decodeMode($past(standbySelect), $past(standbyDepthSelect)))
		else $error("standby bits not sampled at sleep");

endmodule // power_down_mode_control

`default_nettype wire

// File: power_down_pkg.sv
// Constants, state type and reset values for the power-down mode controller.
// Assumes one system clock; all users import the whole package.
`default_nettype none

package power_down_pkg;

	// ==========================================================
	// Module stop register layout
	localparam int STOP_REG_COUNT = 4;
	localparam int STOP_REG_WIDTH = 8;
	localparam int MODULE_COUNT = STOP_REG_COUNT * STOP_REG_WIDTH;
	// Reset value of the module stop bits, one bit per module
	localparam logic [31:0] MODULE_STOP_RESET = 32'h0000_00F0;

	// ==========================================================
	// Standby control bit encodings
	localparam logic STANDBY_SELECT_SLEEP = 1'b0;
	localparam logic STANDBY_SELECT_STANDBY = 1'b1;
	localparam logic STANDBY_DEPTH_DEEP = 1'b0;
	localparam logic STANDBY_DEPTH_SOFT = 1'b1;

	// ==========================================================
	// Timing
	localparam int SYNC_STAGES = 2;

	// ==========================================================
	// Controller states
	typedef enum logic [2:0] {
		ST_RUN,
		ST_WAIT_BUS,
		ST_SLEEP,
		ST_SOFT_STANDBY,
		ST_DEEP_STANDBY
	} power_state_e;

endpackage

`default_nettype wire

// File: power_down_mode_control_tb.sv
// Self-checking bench for the power-down mode controller.
// Assumes power_down_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none

module power_down_mode_control_tb;
	import power_down_pkg::*;

	// ==========================================================
	// Mode vector: clockGen, cpu, regsHeld, mem, periph, undefined, state
	localparam logic [8:0] MODE_RUN = 9'h000;
	localparam logic [8:0] MODE_WAIT = 9'h0C1;
	localparam logic [8:0] MODE_SLEEP = 9'h0C2;
	localparam logic [8:0] MODE_SOFT = 9'h1F3;
	localparam logic [8:0] MODE_DEEP = 9'h1BC;

	logic clk, rst_b, sleepExec, busIdle, standbySelect, standbyDepthSelect, nmiPin, irqPin;
	logic [3:0] moduleStopWe;
	logic [7:0] moduleStopData;
	logic clockGenHalt, cpuHalt, cpuRegsHeld, memHalt, periphHalt, contentsUndefined;
	logic [31:0] moduleHalt;
	logic [2:0] powerState;
	logic [8:0] modeVec;
	int failCount;
	int nTests;
	int cycles;

	assign modeVec = {clockGenHalt, cpuHalt, cpuRegsHeld, memHalt, periphHalt, contentsUndefined, powerState};

	power_down_mode_control dut (
		.clk(clk),
		.rst_b(rst_b),
		.sleepExec(sleepExec),
		.busIdle(busIdle),
		.standbySelect(standbySelect),
		.standbyDepthSelect(standbyDepthSelect),
		.moduleStopWe(moduleStopWe),
		.moduleStopData(moduleStopData),
		.nmiPin(nmiPin),
		.irqPin(irqPin),
		.clockGenHalt(clockGenHalt),
		.cpuHalt(cpuHalt),
		.cpuRegsHeld(cpuRegsHeld),
		.memHalt(memHalt),
		.periphHalt(periphHalt),
		.contentsUndefined(contentsUndefined),
		.moduleHalt(moduleHalt),
		.powerState(powerState)
	);

	// ==========================================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// The whole run needs about 76 cycles; the ceiling leaves ample slack
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			failCount++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Tasks
	task automatic report_and_stop();
		if (failCount == 0 && nTests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			failCount++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// Inputs always move 2 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic do_reset();
		rst_b = 1'b0;
		tick(5);
		rst_b = 1'b1;
		tick(3);
	endtask

	task automatic write_stop(input logic [3:0] we, input logic [7:0] d);
		moduleStopWe = we;
		moduleStopData = d;
		tick(1);
		moduleStopWe = 4'h0;
	endtask

	// Select bits are flipped right after the sampling edge; the bus stays busy a while
	task automatic enter_mode(input logic sel, input logic depth, input logic [8:0] expMode);
		sleepExec = 1'b1;
		standbySelect = sel;
		standbyDepthSelect = depth;
		busIdle = 1'b0;
		tick(1);
		sleepExec = 1'b0;
		standbySelect = ~sel;
		standbyDepthSelect = ~depth;
		check("mode while bus busy", 32'(modeVec), 32'(MODE_WAIT));
		tick(3);
		check("mode still waiting", 32'(modeVec), 32'(MODE_WAIT));
		busIdle = 1'b1;
		tick(1);
		check("mode entered", 32'(modeVec), 32'(expMode));
	endtask

	task automatic wake(input logic useNmi);
		nmiPin = useNmi;
		irqPin = ~useNmi;
		tick(2);
		check("mode before wake", 32'(modeVec), 32'(MODE_SOFT));
		tick(1);
		check("mode after wake", 32'(modeVec), 32'(MODE_RUN));
		nmiPin = 1'b0;
		irqPin = 1'b0;
		tick(3);
	endtask

	// Interrupts and a fresh sleep request that a halted mode must ignore
	task automatic poke(input logic [8:0] expMode);
		nmiPin = 1'b1;
		irqPin = 1'b1;
		sleepExec = 1'b1;
		standbySelect = 1'b1;
		standbyDepthSelect = 1'b1;
		tick(1);
		sleepExec = 1'b0;
		tick(4);
		nmiPin = 1'b0;
		irqPin = 1'b0;
		tick(3);
		check("mode after poke", 32'(modeVec), 32'(expMode));
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst_b = 1'b0;
		sleepExec = 1'b0;
		busIdle = 1'b1;
		standbySelect = 1'b0;
		standbyDepthSelect = 1'b0;
		nmiPin = 1'b0;
		irqPin = 1'b0;
		moduleStopWe = 4'h0;
		moduleStopData = 8'h00;
		failCount = 0;
		nTests = 0;
		cycles = 0;
		do_reset();
		check("moduleHalt at reset", moduleHalt, 32'h000000F0);
		check("mode at reset", 32'(modeVec), 32'(MODE_RUN));
		write_stop(4'h1, 8'h03);
		check("moduleHalt one reg", moduleHalt, 32'h00000003);
		write_stop(4'hA, 8'hA5);
		check("moduleHalt two regs", moduleHalt, 32'hA500A503);
		check("mode in module standby", 32'(modeVec), 32'(MODE_RUN));
		write_stop(4'h1, 8'h00);
		check("moduleHalt cleared", moduleHalt, 32'hA500A500);
		enter_mode(1'b1, 1'b1, MODE_SOFT);
		check("moduleHalt in standby", moduleHalt, 32'hA500A500);
		wake(1'b0);
		enter_mode(1'b1, 1'b1, MODE_SOFT);
		wake(1'b1);
		enter_mode(1'b0, 1'b0, MODE_SLEEP);
		poke(MODE_SLEEP);
		do_reset();
		check("mode after sleep reset", 32'(modeVec), 32'(MODE_RUN));
		write_stop(4'h4, 8'h5A);
		check("moduleHalt third reg", moduleHalt, 32'h005A00F0);
		enter_mode(1'b1, 1'b0, MODE_DEEP);
		poke(MODE_DEEP);
		do_reset();
		check("mode after deep reset", 32'(modeVec), 32'(MODE_RUN));
		check("moduleHalt after reset", moduleHalt, 32'h000000F0);
		report_and_stop();
	end

endmodule // power_down_mode_control_tb

`default_nettype wire
